// file: design/fsfifo_cfg.svh
`ifndef FSFIFO_CFG_SVH
`define FSFIFO_CFG_SVH

// fifo shape
`define FS_DEPTH            10
`define FS_CNT_W            14
`define FS_STAT_W           5

// ahb byte offsets, one word per register
`define OFF_CTRL            8'h00
`define OFF_LIVE            8'h04
`define OFF_EVENT           8'h08
`define OFF_RD_BASE         8'h20

// control register fields
`define CTRL_FIFO_EN_BIT    2
`define CTRL_SDLC_BIT       8
`define CTRL_RXINT_LSB      9
`define CTRL_RESET          16'h0000

// receive interrupt modes
`define RXINT_DISABLED      2'h0
`define RXINT_FIRST_OR_SPEC 2'h1
`define RXINT_ALL           2'h2
`define RXINT_SPEC_ONLY     2'h3

// event register bits (write one to strobe)
`define EV_DATA_WR_BIT      0
`define EV_FLAG_BIT         1
`define EV_EOF_BIT          2
`define EV_UNLOCK_BIT       3
`define EV_CHAN_RST_BIT     4

// special receive status field positions
`define SRS_ALL_SENT_BIT    0
`define SRS_RESIDUE_LSB     1
`define SRS_PARITY_BIT      4
`define SRS_OVERRUN_BIT     5
`define SRS_CRC_BIT         6
`define SRS_EOF_BIT         7

// upper count register flags
`define CHI_AVAIL_BIT       6
`define CHI_OVF_BIT         7

// extended status enable read register
`define XSE_FIFO_EN_BIT     2

`endif

// file: design/fsfifo_pkg.sv
package fsfifo_pkg;

    // one queued frame: count plus residue, overrun and crc bits
    typedef struct packed {
        logic [13:0] count;
        logic [2:0]  residue;
        logic        overrun;
        logic        crc_err;
    } fs_entry_t;

    typedef struct packed {
        logic [1:0]  htrans;
        logic [31:0] haddr;
        logic        hwrite;
        logic [2:0]  hsize;
    } ahb_addr_t;

    typedef enum logic [1:0] {
        sel_live,
        sel_queue
    } src_sel_t;

endpackage

// file: design/fs_queue.sv
`timescale 1ns/1ps
`include "fsfifo_cfg.svh"

module fs_queue
    import fsfifo_pkg::*;
#(
    parameter int DEPTH = `FS_DEPTH
) (
    input  wire logic      clk,
    input  wire logic      clear,
    input  wire logic      push,
    input  wire fs_entry_t push_data,
    input  wire logic      pop,
    output fs_entry_t      head,
    output logic           not_empty,
    output logic           overflow
);
    localparam int AW = $clog2(DEPTH);

    fs_entry_t       mem [DEPTH];
    logic [AW-1:0]   wr_q;
    logic [AW-1:0]   rd_q;
    logic [AW:0]     cnt_q;

    function automatic logic [AW-1:0] inc_ptr(input logic [AW-1:0] p);
        inc_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    wire logic full_w = (cnt_q == (AW+1)'(DEPTH));
    wire logic do_pop = pop && (cnt_q != '0);
    wire logic do_push = push && !full_w;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_q] <= push_data;
        end
    end

    // ------------------------------------------------------------
    // pointers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (clear) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) begin
                wr_q <= inc_ptr(wr_q);
            end
            if (do_pop) begin // [RULE17]
                rd_q <= inc_ptr(rd_q);
            end
            cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    // ------------------------------------------------------------
    // overflow, sticky until cleared
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (clear) begin
            overflow <= 1'b0;
        end else if (push && full_w) begin // [RULE4]
            overflow <= 1'b1;
        end
    end

    assign head      = mem[rd_q];
    assign not_empty = (cnt_q != '0);
endmodule

// file: design/sdlc_frame_status_fifo.sv
`timescale 1ns/1ps
`include "fsfifo_cfg.svh"

// Function
// RULE1 - per channel, ten by nineteen status queue apart from data queue
// RULE2 - closing flag with queue on pushes byte count and five status bits
// RULE3 - crc checker reset pulsed after every frame end
// RULE4 - ten frames held; an eleventh frame end is an overrun
// RULE5 - queue and rx interrupts on: frame end never locks data queue
// RULE6 - queue off: frame end locks data queue in two special modes
// RULE7 - queue active only with enable bit and sdlc mode, else bypass
// RULE8 - pointers cleared when disabled, channel reset or power reset
// RULE9 - reset clears enable bit
// RULE10 - queue off: read registers four to seven alias zero to three
// RULE11 - extended status bit 2 shows queue enable
// RULE12 - enabled, not empty: status and counts from head; status read pops
// RULE13 - empty: live status shown, count registers undefined
// RULE14 - upper count bit 6 is data available; its read latches the source
// RULE15 - residue, overrun, crc queued; all sent, parity, eof stay live
// RULE16 - host reads upper count, lower count, then status
// RULE17 - repeated status reads pop once; empty queue never pops
// RULE18 - overflow sets upper count msb; cleared only by enable toggle (code also clears it on power reset, channel reset or sdlc mode off)
// RULE19 - byte counter enabled by sdlc mode with enable bit set
// RULE20 - byte counter cleared on each flag after capture
// RULE21 - byte counter counts writes into the receive data queue
// RULE22 - byte counter wraps at fourteen bits silently
module sdlc_frame_status_fifo
    import fsfifo_pkg::*;
#(
    parameter int DEPTH = `FS_DEPTH
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             crc_reset,
    output logic             data_fifo_locked
);
    // ------------------------------------------------------------
    // ahb address phase capture
    // ------------------------------------------------------------
    ahb_addr_t   ap_q;
    logic        ap_valid_q;
    logic [15:0] ctrl_q;
    logic [7:0]  live_q;
    logic [7:0]  rr_q [4];

    wire logic take = hsel && hready && htrans[1];

    always_ff @(posedge clk) begin
        if (reset) begin
            ap_valid_q <= 1'b0;
            ap_q       <= '0;
        end else begin
            ap_valid_q <= take;
            if (take) begin
                ap_q <= '{htrans: htrans, haddr: haddr, hwrite: hwrite, hsize: hsize};
            end
        end
    end

    wire logic       wr_v  = ap_valid_q && ap_q.hwrite;
    wire logic       rd_a  = take && !hwrite;
    wire logic [7:0] ra    = haddr[7:0];
    wire logic [7:0] wa    = ap_q.haddr[7:0];

    function automatic logic is_rr(input logic [7:0] a, input logic [2:0] n);
        is_rr = (a == `OFF_RD_BASE + {3'h0, n, 2'h0});
    endfunction

    // ------------------------------------------------------------
    // control and live status
    // ------------------------------------------------------------
    wire logic       en_bit = ctrl_q[`CTRL_FIFO_EN_BIT];
    wire logic       sdlc   = ctrl_q[`CTRL_SDLC_BIT];
    wire logic [1:0] rxint  = ctrl_q[`CTRL_RXINT_LSB +: 2];
    wire logic       q_on   = en_bit && sdlc; // [RULE7]
    wire logic [4:0] ev     = (wr_v && wa == `OFF_EVENT) ? hwdata[4:0] : 5'h00;

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_q <= `CTRL_RESET; // [RULE9]
            live_q <= 8'h00;
            for (int i = 0; i < 4; i++) begin
                rr_q[i] <= 8'h00;
            end
        end else if (wr_v) begin
            if (wa == `OFF_CTRL) begin
                ctrl_q <= hwdata[15:0];
            end
            if (wa == `OFF_LIVE) begin
                live_q <= hwdata[7:0];
            end
            for (int i = 0; i < 4; i++) begin
                if (wa == `OFF_RD_BASE + 8'(4 * i) && i != 1) begin
                    rr_q[i] <= hwdata[7:0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // byte counter
    // ------------------------------------------------------------
    logic [13:0] bcnt_q;
    wire logic   bc_en = q_on; // [RULE19]

    always_ff @(posedge clk) begin
        if (reset || !bc_en || ev[`EV_FLAG_BIT] || ev[`EV_EOF_BIT]) begin
            bcnt_q <= '0; // [RULE20]
        end else if (ev[`EV_DATA_WR_BIT]) begin
            bcnt_q <= bcnt_q + 14'h0001; // [RULE21] [RULE22]
        end
    end

    // ------------------------------------------------------------
    // frame status queue
    // ------------------------------------------------------------
    fs_entry_t   head;
    fs_entry_t   push_data;
    logic        not_empty;
    logic        overflow;
    logic        pop;
    src_sel_t    sel_q;
    logic        popped_q;
    logic        chan_rst;

    assign chan_rst  = ev[`EV_CHAN_RST_BIT];
    assign push_data = '{count:   bcnt_q,
                         residue: live_q[`SRS_RESIDUE_LSB +: 3],
                         overrun: live_q[`SRS_OVERRUN_BIT],
                         crc_err: live_q[`SRS_CRC_BIT]}; // [RULE2] [RULE15]

    fs_queue #(
        .DEPTH (DEPTH)
    ) u_queue ( // [RULE1]
        .clk       (clk),
        .clear     (reset || chan_rst || !q_on), // [RULE8] [RULE18]
        .push      (q_on && ev[`EV_EOF_BIT]), // [RULE2] [RULE4]
        .push_data (push_data),
        .head      (head),
        .pop       (pop),
        .not_empty (not_empty),
        .overflow  (overflow)
    );

    // upper count read latches source; status read pops once per latch
    always_ff @(posedge clk) begin
        if (reset || !q_on) begin
            sel_q    <= sel_live;
            popped_q <= 1'b0;
        end else if (rd_a && is_rr(ra, 3'd7)) begin
            sel_q    <= not_empty ? sel_queue : sel_live; // [RULE14]
            popped_q <= 1'b0;
        end else if (pop) begin
            popped_q <= 1'b1; // [RULE17]
        end
    end

    wire logic use_q = q_on && not_empty && sel_q == sel_queue; // [RULE12] [RULE13]
    assign pop = use_q && !popped_q && rd_a && is_rr(ra, 3'd1); // [RULE12] [RULE17]

    // ------------------------------------------------------------
    // crc reset and data queue lock
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            crc_reset <= 1'b0;
        end else begin
            crc_reset <= ev[`EV_EOF_BIT]; // [RULE3]
        end
    end

    always_ff @(posedge clk) begin
        if (reset || ev[`EV_UNLOCK_BIT] || chan_rst) begin
            data_fifo_locked <= 1'b0;
        end else if (ev[`EV_EOF_BIT] && !q_on &&
                     (rxint == `RXINT_FIRST_OR_SPEC || rxint == `RXINT_SPEC_ONLY)) begin
            data_fifo_locked <= 1'b1; // [RULE6]
        end else if (q_on && rxint != `RXINT_DISABLED) begin
            data_fifo_locked <= 1'b0; // [RULE5]
        end
    end

    // ------------------------------------------------------------
    // read data mux
    // ------------------------------------------------------------
    function automatic logic [7:0] status_view(input logic qsel, input fs_entry_t e,
                                               input logic [7:0] live);
        logic [7:0] v;
        v = live;
        if (qsel) begin
            v[`SRS_RESIDUE_LSB +: 3] = e.residue;
            v[`SRS_OVERRUN_BIT]      = e.overrun;
            v[`SRS_CRC_BIT]          = e.crc_err;
        end
        status_view = v; // [RULE15]
    endfunction

    logic [7:0] rd_byte;
    logic [2:0] idx;

    always_comb begin
        rd_byte = 8'h00;
        idx     = ra[4:2];
        if (ra == `OFF_CTRL) begin
            rd_byte = ctrl_q[7:0];
        end else if (ra == `OFF_LIVE) begin
            rd_byte = live_q;
        end else if (ra[7:5] == 3'h1 && ra[1:0] == 2'h0) begin
            if (!q_on && idx[2]) begin
                idx = {1'b0, idx[1:0]}; // [RULE10]
            end
            unique case (idx)
                3'd1:    rd_byte = status_view(use_q, head, live_q); // [RULE12]
                3'd4:    rd_byte = rr_q[0];
                3'd5:    rd_byte = status_view(use_q, head, live_q);
                3'd6:    rd_byte = head.count[7:0];
                3'd7:    rd_byte = {overflow, not_empty, head.count[13:8]}; // [RULE14] [RULE18]
                default: rd_byte = rr_q[idx[1:0]];
            endcase
        end else if (ra == `OFF_RD_BASE + 8'h3C) begin
            rd_byte = {5'h00, en_bit, 2'h0}; // [RULE11]
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_a) begin
            hrdata <= {24'h00_0000, rd_byte};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end
endmodule

// file: test/fsfifo_sva.sv
`timescale 1ns/1ps
module fsfifo_sva #(
    parameter int DEPTH = 10
) (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        crc_reset,
    input wire logic        data_fifo_locked
);
    logic        take_q;
    logic        wr_q;
    logic [7:0]  a_q;
    logic [10:0] ctrl_q;
    logic [4:0]  occ_q;
    logic        lat_q;
    logic        ovf_q;
    logic        eof_dp;
    logic        rd_dp;
    logic        act;
    logic        rd_ap;
    logic        pop;
    assign eof_dp = take_q && wr_q && a_q == 8'h08 && hwdata[2];
    assign rd_dp = take_q && !wr_q;
    assign act = ctrl_q[2] && ctrl_q[8];
    assign rd_ap = hsel && hready && htrans[1] && !hwrite;
    assign pop = rd_ap && haddr[7:0] == 8'h24 && lat_q;
    // ------------
    // bus shadow and queue model
    // ------------
    always_ff @(posedge clk) begin
        take_q <= !reset && hsel && hready && htrans[1];
        wr_q <= hwrite;
        a_q <= haddr[7:0];
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_q <= '0;
        end else if (take_q && wr_q && a_q == 8'h00) begin
            ctrl_q <= hwdata[10:0];
        end
    end
    always_ff @(posedge clk) begin
        if (reset || !act || (take_q && wr_q && a_q == 8'h08 && hwdata[4])) begin
            occ_q <= '0;
            lat_q <= 1'b0;
            ovf_q <= 1'b0;
        end else begin
            occ_q <= occ_q + 5'(eof_dp && occ_q != DEPTH) - 5'(pop);
            ovf_q <= ovf_q || (eof_dp && occ_q == DEPTH);
            if (pop) begin
                lat_q <= 1'b0;
            end else if (rd_ap && haddr[7:0] == 8'h3C) begin
                lat_q <= occ_q != 0;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_crc_pulse;
        eof_dp && ctrl_q[8] |=> crc_reset;
    endproperty
    a_crc_pulse: assert property (p_crc_pulse) else $error("crc reset missing");
    property p_crc_only;
        crc_reset |-> $past(eof_dp);
    endproperty
    a_crc_only: assert property (p_crc_only) else $error("stray crc reset");
    property p_lock_set;
        eof_dp && !ctrl_q[2] && ctrl_q[8] && ctrl_q[9] |-> ##[1:3] data_fifo_locked;
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("data queue not locked");
    property p_lock_none;
        eof_dp && act && ctrl_q[10:9] != 2'h0 && !data_fifo_locked |=> !data_fifo_locked [*3];
    endproperty
    a_lock_none: assert property (p_lock_none) else $error("data queue locked");
    property p_lock_cause;
        $rose(data_fifo_locked) |-> $past(eof_dp) || $past(eof_dp, 2) || $past(eof_dp, 3);
    endproperty
    a_lock_cause: assert property (p_lock_cause) else $error("lock without eof");
    property p_xse;
        rd_dp && a_q == 8'h5C |-> hrdata[2] == ctrl_q[2];
    endproperty
    a_xse: assert property (p_xse) else $error("enable bit wrong");
    property p_avail;
        rd_dp && a_q == 8'h3C && act |-> hrdata[6] == (occ_q != 0);
    endproperty
    a_avail: assert property (p_avail) else $error("avail flag wrong");
    property p_ovf;
        rd_dp && a_q == 8'h3C && act |-> hrdata[7] == ovf_q;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag wrong");
endmodule

bind sdlc_frame_status_fifo fsfifo_sva #(.DEPTH(DEPTH)) i_sva (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .crc_reset(crc_reset), .data_fifo_locked(data_fifo_locked)
);

// file: test/ahb_host.sv
`timescale 1ns/1ps
module ahb_host (
    input  wire logic        clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    output logic             stuck
);
    initial begin
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = '0;
        stuck = 1'b0;
    end
    // single word transfer, bounded waits on hready
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        htrans <= 2'h0;
        hwdata <= wr ? wd : ~hwdata;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        rd = hrdata;
        hsel <= 1'b0;
        hwdata <= ~hwdata;
        if (n >= 64) begin
            stuck = 1'b1;
        end
    endtask
endmodule

// file: test/sdlc_frame_status_fifo_test.sv
`timescale 1ns/1ps
`define CHK(act, exp) \
    begin \
        num_checks++; \
        if ((act) !== (exp)) begin \
            fails++; \
            $display("[FAIL] t=%0t got %h exp %h", $time, act, exp); \
        end \
    end
module sdlc_frame_status_fifo_test;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        crc_reset;
    logic        locked;
    logic        stuck;
    logic [31:0] r;
    int          fails = 0;
    int          num_checks = 0;
    // rows: {-, lock_exp, lock_care, write}, address, data or expected byte
    logic [23:0] rows [$] = '{
        24'h0_00_000, 24'h0_5C_000, 24'h1_20_011, 24'h1_28_022, 24'h1_2C_033,
        24'h1_04_0A5, 24'h0_30_011, 24'h0_34_0A5, 24'h0_38_022, 24'h0_3C_033,
        24'h0_24_0A5, 24'h1_00_700, 24'h1_08_004, 24'h0_20_011, 24'h6_24_0A5,
        24'h1_08_008, 24'h1_00_300, 24'h2_20_011, 24'h1_08_004, 24'h0_20_011,
        24'h6_20_011, 24'h1_08_008, 24'h1_00_704, 24'h2_5C_004, 24'h1_08_002,
        24'h1_08_001, 24'h1_08_001, 24'h1_08_001, 24'h1_04_05A, 24'h1_08_004,
        24'h1_00_304, 24'h2_20_011, 24'h1_08_001, 24'h1_08_002, 24'h1_08_001,
        24'h1_08_001, 24'h1_04_091, 24'h1_08_004, 24'h0_20_011, 24'h2_3C_040,
        24'h0_38_003, 24'h0_24_0DB, 24'h0_24_091, 24'h0_3C_040, 24'h0_38_002,
        24'h0_24_091, 24'h0_3C_000, 24'h0_24_091, 24'h1_00_004, 24'h1_08_001,
        24'h1_04_05A, 24'h1_08_004, 24'h1_04_0A5, 24'h0_3C_033, 24'h0_24_0A5
    };
    always #4 clk = ~clk;
    sdlc_frame_status_fifo i_dut (
        .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .crc_reset(crc_reset), .data_fifo_locked(locked)
    );
    ahb_host i_host (
        .clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .stuck(stuck)
    );
    task automatic wr(input logic [7:0] a, input logic [11:0] d);
        i_host.xfer(1'b1, a, {20'h0, d}, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_host.xfer(1'b0, a, 32'h0, r);
        `CHK(r[7:0], e)
    endtask
    task automatic report_and_stop;
        if (stuck !== 1'b0) begin
            fails++;
        end
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        foreach (rows[k]) begin
            @(negedge clk);
            if (rows[k][21]) begin
                `CHK(locked, rows[k][22])
            end
            if (rows[k][20]) begin
                wr(rows[k][19:12], rows[k][11:0]);
            end else begin
                rd(rows[k][19:12], rows[k][7:0]);
            end
        end
        // ------------
        // overflow, drain, enable toggle
        // ------------
        wr(8'h00, 12'h704);
        wr(8'h08, 12'h002);
        for (int i = 0; i < 11; i++) begin
            wr(8'h08, 12'h001);
            wr(8'h08, 12'h004);
            if (i == 9) begin
                rd(8'h3C, 8'h40);
            end
        end
        for (int i = 0; i < 10; i++) begin
            rd(8'h3C, 8'hC0);
            rd(8'h38, 8'h01);
            rd(8'h24, 8'hA5);
        end
        rd(8'h3C, 8'h80);
        wr(8'h00, 12'h700);
        wr(8'h00, 12'h704);
        rd(8'h3C, 8'h00);
        wr(8'h08, 12'h001);
        wr(8'h08, 12'h004);
        wr(8'h08, 12'h010);
        i_host.xfer(1'b0, 8'h3C, 32'h0, r);
        `CHK(r[6], 1'b0)
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rd(8'h00, 8'h00);
        rd(8'h5C, 8'h00);
        report_and_stop();
    end
endmodule
